//--- ibc_bus_model.sv
// Purpose: arbiter and slave standing on the far bus side
// Assumes: fault 0 ack, 1 error, 2 retry, 3 never answers
// Notes: answers on the third strobed cycle, never resizes
`timescale 1ns/1ps
`default_nettype none
module ibc_bus_model
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic bus_req,
  input wire logic bus_as,
  input wire logic [1:0] fault,
  output logic bus_grant,
  output logic bus_ack,
  output logic bus_retry,
  output logic bus_err,
  output logic bus_size_ack,
  output logic [31:0] bus_rdata
);
  localparam logic [31:0] RD_WORD = 32'h5a3c_0f96;
  logic [1:0] wait_q;
  logic fin;
  assign fin = bus_as && wait_q == 2'h2;
  assign bus_ack = fin && fault == 2'h0;
  assign bus_err = fin && fault == 2'h1;
  assign bus_retry = fin && fault == 2'h2;
  assign bus_size_ack = 1'b0;
  // outside the answer the lines show the inverse, so stale capture is caught
  assign bus_rdata = bus_ack ? RD_WORD : ~RD_WORD;
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n) {bus_grant, wait_q} <= 3'h0;
    else {bus_grant, wait_q} <= {bus_req, bus_as ? wait_q + 2'h1 : 2'h0};
endmodule : ibc_bus_model
`default_nettype wire

//--- ibc_cpu_port.sv
// Functional notes
// - bus bursts carry at most sixteen bytes each.
// - no bus interrupts and no bus reset handled here.
// - master for programmed io, controller plus slave local, controller only bypass.
// - translation done before bus request, so bus sees only slave cycle.
// - writes posted; processor stalls only on a further access meanwhile.
// - reads stall processor until data valid at end of bus cycle.
// - dma is translation cycle, then slave cycle chosen from physical address.
// - local dma stages up to sixteen bytes: get, then put.
// - local read: internal get, then bus slave put.
// - local write: bus slave get ends transfer; put delays next translation.
// - bypass: no slave role, no get or put.
// - bus error in programmed io exposes cycle state to mmu.
// - bus error in dma: controller ends slave cycle with error ack.
// - watchdog expiry ends slave cycle with error.
// - byte, half, word and double sizes supported.
// - full copy of current cycle kept for sizing, split, retry; here it serves split and retry only, nothing is resized.
// - collision: hold programmed io, run dma, then resume held cycle.
// - read data ready shown by request signal.
// - idle, request until grant, hold until release, housekeeping for reads.
// - double to burst-incapable slot split into words, pending held.
// - sizing and retry handled in either half of split; here only retry is, a size ack with ack just keeps the port in grant.
// - retry ends cycle, frees bus, admits dma, restarts from start.
//
// Purpose: processor-side state machine and dma sequencing of the io bus controller
// Assumes: mmu translates addresses; arbiter and slave pins live elsewhere
// Notes: all outputs registered; clk_en freezes every flop
`timescale 1ns/1ps
`default_nettype none
module ibc_cpu_port
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic cycle_strobe_n,
  input wire logic cpu_write,
  input wire logic [1:0] cpu_size,
  input wire logic [31:0] cpu_paddr,
  input wire logic [63:0] cpu_wdata,
  input wire logic slot_burst_ok,
  output logic controller_pending,
  output logic read_ready_request,
  output logic [63:0] cpu_rdata,
  output logic pio_error,
  output logic [31:0] err_addr,
  output logic [1:0] err_size,
  output logic err_write,
  output logic bus_req,
  input wire logic bus_grant,
  output logic bus_as,
  output logic [31:0] bus_addr,
  output logic [1:0] bus_size,
  output logic bus_write,
  output logic [31:0] bus_wdata,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_ack,
  input wire logic bus_retry,
  input wire logic bus_err,
  input wire logic bus_size_ack,
  input wire logic virtual_dma_transfer_trans_done,
  input wire logic virtual_dma_transfer_local,
  input wire logic virtual_dma_transfer_write,
  input wire logic [4:0] virtual_dma_transfer_len,
  input wire logic virtual_dma_transfer_done,
  output logic virtual_dma_transfer_get,
  output logic virtual_dma_transfer_put,
  output logic virtual_dma_transfer_slave_sel,
  output logic virtual_dma_transfer_err_ack,
  output logic virtual_dma_transfer_busy
);
  ibc_pkg::ibc_state_t st_q, st_d;
  logic [31:0] addr_q;
  logic [63:0] wdata_q;
  logic [1:0] size_q;
  logic write_q;
  logic split_q;
  logic half_q;
  logic held_q;
  logic [63:0] rbuf_q;
  logic [4:0] stage_q;
  logic dwr_q;
  logic wd_expire;
  ibc_pkg::ibc_state_t virtual_dma_transfer_st;

  // cycle state copy lets the port split and retry without the mmu; a size ack resizes nothing
  wire strobe = !cycle_strobe_n && !controller_pending;
  wire need_split = (size_q == ibc_pkg::SIZE_DWORD) && !split_q;
  // internal get or put steps never stall on a slave, so the watchdog skips them
  wire slave_open = (st_q == ibc_pkg::CSM_GRANT)
    || (st_q == ibc_pkg::CSM_VIRTUAL_DMA_TRANSFER_GET && dwr_q)
    || (st_q == ibc_pkg::CSM_VIRTUAL_DMA_TRANSFER_PUT && !dwr_q);
  wire any_err = bus_err || wd_expire;
  wire last_half = !split_q || half_q;
  wire virtual_dma_transfer_req = virtual_dma_transfer_trans_done && !virtual_dma_transfer_busy;
  wire [4:0] clip_len = (virtual_dma_transfer_len > 5'(ibc_pkg::BURST_MAX_BYTES))
    ? 5'(ibc_pkg::BURST_MAX_BYTES) : virtual_dma_transfer_len;
  wire hold_exit = (st_q == ibc_pkg::CSM_HOLD) && !bus_grant;
  wire pio_final = hold_exit && (last_half || pio_error);
  wire to_house = (st_q == ibc_pkg::CSM_HOLD) && (st_d == ibc_pkg::CSM_HOUSE);
  // the upper word lands first; the second half of a split fills the lower word
  wire rd_capture = (st_q == ibc_pkg::CSM_GRANT) && bus_ack;
  wire virtual_dma_transfer_take = virtual_dma_transfer_req
    && ((st_q == ibc_pkg::CSM_IDLE) || (st_q == ibc_pkg::CSM_REQ));
  // local transfers always stage through get then put; only the bus side differs
  assign virtual_dma_transfer_st = virtual_dma_transfer_local ? ibc_pkg::CSM_VIRTUAL_DMA_TRANSFER_GET : ibc_pkg::CSM_VIRTUAL_DMA_TRANSFER_BYP;

  function automatic logic [31:0] next_word(input logic [31:0] a);
    next_word = a + 32'(ibc_pkg::WORD_STEP);
  endfunction : next_word

  function automatic logic is_virtual_dma_transfer(input ibc_pkg::ibc_state_t s);
    is_virtual_dma_transfer = (s == ibc_pkg::CSM_VIRTUAL_DMA_TRANSFER_GET) || (s == ibc_pkg::CSM_VIRTUAL_DMA_TRANSFER_PUT)
      || (s == ibc_pkg::CSM_VIRTUAL_DMA_TRANSFER_BYP);
  endfunction : is_virtual_dma_transfer

  ibc_wdog u_wdog
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .run(slave_open && !bus_ack),
    .expire(wd_expire)
  );

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      ibc_pkg::CSM_IDLE:
      begin
        if (virtual_dma_transfer_req)
          st_d = virtual_dma_transfer_st;
        else if (held_q || strobe)
          st_d = ibc_pkg::CSM_REQ;
      end
      ibc_pkg::CSM_REQ:
      begin
        // the translation pulse lasts one cycle, so it is taken here, not replayed
        if (virtual_dma_transfer_req)
          st_d = virtual_dma_transfer_st;
        else if (bus_grant)
          st_d = ibc_pkg::CSM_GRANT;
      end
      ibc_pkg::CSM_GRANT:
      begin
        // a retry keeps the held copy, so the same half reruns once the bus is won
        if (bus_retry)
          st_d = ibc_pkg::CSM_IDLE;
        else if (any_err || (bus_ack && !bus_size_ack))
          st_d = ibc_pkg::CSM_HOLD;
      end
      ibc_pkg::CSM_HOLD:
      begin
        // the arbiter takes grant back before the next half or the exit
        if (!bus_grant)
        begin
          if (pio_error || !last_half)
            st_d = pio_error ? ibc_pkg::CSM_IDLE : ibc_pkg::CSM_REQ;
          else
            st_d = write_q ? ibc_pkg::CSM_IDLE : ibc_pkg::CSM_HOUSE;
        end
      end
      ibc_pkg::CSM_HOUSE:
        st_d = ibc_pkg::CSM_IDLE;
      // local read: internal get shows as a pause, then slave put
      ibc_pkg::CSM_VIRTUAL_DMA_TRANSFER_GET:
      begin
        if (virtual_dma_transfer_done || any_err)
          st_d = ibc_pkg::CSM_VIRTUAL_DMA_TRANSFER_PUT;
      end
      // put follows get; for writes the bus part was the get, the store is internal
      ibc_pkg::CSM_VIRTUAL_DMA_TRANSFER_PUT:
      begin
        if (virtual_dma_transfer_done || any_err)
          st_d = ibc_pkg::CSM_IDLE;
      end
      ibc_pkg::CSM_VIRTUAL_DMA_TRANSFER_BYP:
      begin
        if (virtual_dma_transfer_done || any_err)
          st_d = ibc_pkg::CSM_IDLE;
      end
      default:
        st_d = ibc_pkg::CSM_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= ibc_pkg::CSM_IDLE;
      addr_q <= ibc_pkg::RESET_ADDR;
      wdata_q <= ibc_pkg::RESET_DATA;
      size_q <= ibc_pkg::SIZE_BYTE;
      write_q <= 1'b0;
      split_q <= 1'b0;
      half_q <= 1'b0;
      held_q <= 1'b0;
      rbuf_q <= ibc_pkg::RESET_DATA;
      stage_q <= 5'h00;
      dwr_q <= 1'b0;
    end
    else if (clk_en)
    begin
      st_q <= st_d;
      if (strobe)
      begin
        addr_q <= cpu_paddr;
        wdata_q <= cpu_wdata;
        size_q <= cpu_size;
        write_q <= cpu_write;
        split_q <= (cpu_size == ibc_pkg::SIZE_DWORD) && !slot_burst_ok;
        half_q <= 1'b0;
        held_q <= 1'b1;
      end
      else if (hold_exit)
      begin
        if (!pio_final)
        begin
          half_q <= 1'b1;
          addr_q <= next_word(addr_q);
        end
        else
          held_q <= 1'b0;
      end
      if (rd_capture)
      begin
        if (half_q)
          rbuf_q[31:0] <= bus_rdata;
        else
          rbuf_q[63:32] <= bus_rdata;
      end
      if (virtual_dma_transfer_take)
      begin
        stage_q <= clip_len;
        dwr_q <= virtual_dma_transfer_write;
      end
      else if (st_d == ibc_pkg::CSM_IDLE)
        stage_q <= 5'h00;
    end
  end

  // outputs straight from flops; a retry keeps pending high and restarts quietly
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      controller_pending <= 1'b0;
      read_ready_request <= 1'b0;
      cpu_rdata <= ibc_pkg::RESET_DATA;
      pio_error <= 1'b0;
      err_addr <= ibc_pkg::RESET_ADDR;
      err_size <= ibc_pkg::SIZE_BYTE;
      err_write <= 1'b0;
      bus_req <= 1'b0;
      bus_as <= 1'b0;
      bus_addr <= ibc_pkg::RESET_ADDR;
      bus_size <= ibc_pkg::SIZE_BYTE;
      bus_write <= 1'b0;
      bus_wdata <= 32'h0000_0000;
      virtual_dma_transfer_get <= 1'b0;
      virtual_dma_transfer_put <= 1'b0;
      virtual_dma_transfer_slave_sel <= 1'b0;
      virtual_dma_transfer_err_ack <= 1'b0;
      virtual_dma_transfer_busy <= 1'b0;
    end
    else if (clk_en)
    begin
      // posted write frees the cpu; a second access waits on pending
      controller_pending <= strobe || (held_q && !pio_final)
        || (st_d == ibc_pkg::CSM_HOUSE);
      read_ready_request <= to_house;
      if (to_house)
        cpu_rdata <= split_q ? rbuf_q : {rbuf_q[63:32], bus_rdata};
      if (strobe)
        pio_error <= 1'b0;
      else if (st_q == ibc_pkg::CSM_GRANT && any_err)
      begin
        pio_error <= 1'b1;
        err_addr <= addr_q;
        err_size <= size_q;
        err_write <= write_q;
      end
      bus_req <= (st_d == ibc_pkg::CSM_REQ) || (st_d == ibc_pkg::CSM_GRANT);
      bus_as <= st_d == ibc_pkg::CSM_GRANT;
      bus_addr <= addr_q;
      bus_size <= split_q ? ibc_pkg::SIZE_WORD : size_q;
      bus_write <= write_q;
      bus_wdata <= half_q ? wdata_q[31:0] : wdata_q[63:32];
      virtual_dma_transfer_busy <= is_virtual_dma_transfer(st_d);
      virtual_dma_transfer_get <= st_d == ibc_pkg::CSM_VIRTUAL_DMA_TRANSFER_GET;
      virtual_dma_transfer_put <= st_d == ibc_pkg::CSM_VIRTUAL_DMA_TRANSFER_PUT;
      virtual_dma_transfer_slave_sel <= (st_d == ibc_pkg::CSM_VIRTUAL_DMA_TRANSFER_GET) || (st_d == ibc_pkg::CSM_VIRTUAL_DMA_TRANSFER_PUT);
      virtual_dma_transfer_err_ack <= any_err && is_virtual_dma_transfer(st_q);
    end
  end
  // bus interrupts and bus reset are not driven here
endmodule : ibc_cpu_port
`default_nettype wire

//--- ibc_cpu_port_chk.sv
// Purpose: port assertions for ibc_cpu_port
// Assumes: one clock, rst_n async low
// Notes: watchdog bound is loose, the limit is fixed at 512
`timescale 1ns/1ps
`default_nettype none
module ibc_cpu_port_chk
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic cycle_strobe_n,
  input wire logic controller_pending,
  input wire logic read_ready_request,
  input wire logic bus_req,
  input wire logic bus_grant,
  input wire logic bus_as,
  input wire logic virtual_dma_transfer_get,
  input wire logic virtual_dma_transfer_put,
  input wire logic virtual_dma_transfer_slave_sel,
  input wire logic virtual_dma_transfer_busy
);
  logic [9:0] as_run_q;
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n) as_run_q <= 10'h000;
    else as_run_q <= bus_as ? as_run_q + 10'h001 : 10'h000;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence take_s;
    clk_en && !cycle_strobe_n && !controller_pending;
  endsequence
  chk_take_pend:
    assert property (take_s |=> controller_pending) else $error("no pending after strobe");
  chk_take_req:
    assert property (take_s |=> bus_req || virtual_dma_transfer_busy) else $error("no bus request after strobe");
  chk_as_grant:
    assert property ($rose(bus_as) |-> $past(bus_grant)) else $error("strobe without grant");
  chk_rrq_pulse:
    assert property (read_ready_request |=> !read_ready_request) else $error("ready too long");
  chk_rrq_busy:
    assert property (read_ready_request |-> controller_pending) else $error("ready while idle");
  chk_reset_idle:
    assert property ($rose(rst_n) |-> !controller_pending && !bus_req && !bus_as)
      else $error("busy after reset");
  chk_get_put:
    assert property (!(virtual_dma_transfer_get && virtual_dma_transfer_put)) else $error("get and put together");
  chk_stage_slave:
    assert property (virtual_dma_transfer_get || virtual_dma_transfer_put |-> virtual_dma_transfer_slave_sel) else $error("stage not slave");
  chk_wdog_bound:
    assert property (as_run_q < 10'h258) else $error("slave cycle never ended");
  cover property (read_ready_request);
  cover property (virtual_dma_transfer_get ##[1:50] virtual_dma_transfer_put);
  cover property ($rose(bus_as) && controller_pending);
endmodule : ibc_cpu_port_chk
bind ibc_cpu_port ibc_cpu_port_chk i_chk (.ref_clk, .rst_n, .clk_en, .cycle_strobe_n,
  .controller_pending, .read_ready_request, .bus_req, .bus_grant, .bus_as, .virtual_dma_transfer_get,
  .virtual_dma_transfer_put, .virtual_dma_transfer_slave_sel, .virtual_dma_transfer_busy);
`default_nettype wire

//--- ibc_cpu_port_tb.sv
// Purpose: self-checking bench for ibc_cpu_port
// Assumes: ibc_bus_model on the bus side
// Notes: every wait is bounded, a timeout ends the run
`timescale 1ns/1ps
`default_nettype none
module ibc_cpu_port_tb;
  localparam logic [31:0] EXP_RD = 32'h5a3c_0f96;
  logic ref_clk = 1'b0;
  logic rst_n, clk_en, cycle_strobe_n, cpu_write, slot_burst_ok, controller_pending;
  logic read_ready_request, pio_error, err_write, bus_req, bus_grant, bus_as, bus_write;
  logic bus_ack, bus_retry, bus_err, bus_size_ack, virtual_dma_transfer_trans_done, virtual_dma_transfer_local, virtual_dma_transfer_write;
  logic virtual_dma_transfer_done, virtual_dma_transfer_get, virtual_dma_transfer_put, virtual_dma_transfer_slave_sel, virtual_dma_transfer_err_ack, virtual_dma_transfer_busy, as_d, last_wr;
  logic [1:0] cpu_size, err_size, bus_size, fault, last_sz;
  logic [4:0] virtual_dma_transfer_len;
  logic [31:0] cpu_paddr, err_addr, bus_addr, bus_wdata, bus_rdata, last_wd;
  logic [63:0] cpu_wdata, cpu_rdata;
  logic [31:0] as_addr[$];
  int err_total, comparisons, n0;
  ibc_cpu_port i_dut (.ref_clk, .rst_n, .clk_en, .cycle_strobe_n, .cpu_write, .cpu_size,
    .cpu_paddr, .cpu_wdata, .slot_burst_ok, .controller_pending, .read_ready_request,
    .cpu_rdata, .pio_error, .err_addr, .err_size, .err_write, .bus_req, .bus_grant, .bus_as,
    .bus_addr, .bus_size, .bus_write, .bus_wdata, .bus_rdata, .bus_ack, .bus_retry, .bus_err,
    .bus_size_ack, .virtual_dma_transfer_trans_done, .virtual_dma_transfer_local, .virtual_dma_transfer_write, .virtual_dma_transfer_len, .virtual_dma_transfer_done,
    .virtual_dma_transfer_get, .virtual_dma_transfer_put, .virtual_dma_transfer_slave_sel, .virtual_dma_transfer_err_ack, .virtual_dma_transfer_busy);
  ibc_bus_model i_bus (.ref_clk, .rst_n, .bus_req, .bus_as, .fault, .bus_grant, .bus_ack,
    .bus_retry, .bus_err, .bus_size_ack, .bus_rdata);
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    if (bus_as === 1'b1 && as_d !== 1'b1) as_addr.push_back(bus_addr);
    if (bus_as === 1'b1 && as_d !== 1'b1)
    begin
      last_wd = bus_wdata;
      last_sz = bus_size;
      last_wr = bus_write;
    end
    as_d <= bus_as;
  end
  task results;
    if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task cmp(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  function logic pick(input int s);
    case (s)
      0: pick = read_ready_request;
      1: pick = !controller_pending;
      2: pick = virtual_dma_transfer_get;
      3: pick = virtual_dma_transfer_put;
      4: pick = !virtual_dma_transfer_busy;
      6: pick = virtual_dma_transfer_err_ack;
      default: pick = as_addr.size() > n0;
    endcase
  endfunction : pick
  task wt(input int s);
    int n;
    n = 0;
    while (pick(s) !== 1'b1 && n < 800)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 800)
    begin
      err_total++;
      results;
    end
  endtask : wt
  task programmed_io(input logic wr, input logic [1:0] sz, input logic ok, input logic [31:0] a,
    input logic dv);
    wt(1);
    @(posedge ref_clk);
    cycle_strobe_n <= 1'b0;
    cpu_write <= wr;
    cpu_size <= sz;
    slot_burst_ok <= ok;
    cpu_paddr <= a;
    @(posedge ref_clk);
    cycle_strobe_n <= 1'b1;
    virtual_dma_transfer_trans_done <= dv;
    @(posedge ref_clk);
    virtual_dma_transfer_trans_done <= 1'b0;
  endtask : programmed_io
  task done_pulse;
    @(posedge ref_clk);
    virtual_dma_transfer_done <= 1'b1;
    @(posedge ref_clk);
    virtual_dma_transfer_done <= 1'b0;
  endtask : done_pulse
  task t_read;
    for (logic [1:0] s = 2'h0; s < 2'h3; s++)
    begin
      programmed_io(1'b0, s, 1'b1, 32'h0000_0100, 1'b0);
      wt(0);
      cmp(cpu_rdata[63:32], EXP_RD);
      cmp({last_wr, last_sz}, {1'b0, s});
    end
  endtask : t_read
  task t_write_split;
    programmed_io(1'b1, ibc_pkg::SIZE_WORD, 1'b1, 32'h0000_0200, 1'b0);
    wt(1);
    cmp(last_wd, cpu_wdata[63:32]);
    cmp({last_wr, last_sz}, {1'b1, ibc_pkg::SIZE_WORD});
    n0 = as_addr.size();
    programmed_io(1'b0, ibc_pkg::SIZE_DWORD, 1'b0, 32'h0000_0400, 1'b0);
    wt(0);
    cmp(cpu_rdata, {EXP_RD, EXP_RD});
    cmp(as_addr.size(), n0 + 2);
    cmp(as_addr[n0 + 1], 32'h0000_0404);
    cmp({as_addr[n0], last_sz}, {32'h0000_0400, ibc_pkg::SIZE_WORD});
  endtask : t_write_split
  task t_retry;
    n0 = as_addr.size();
    fault <= 2'h2;
    programmed_io(1'b0, ibc_pkg::SIZE_WORD, 1'b1, 32'h0000_0500, 1'b0);
    wt(5);
    repeat (2) @(posedge ref_clk);
    fault <= 2'h0;
    wt(0);
    cmp(cpu_rdata[63:32], EXP_RD);
    cmp(as_addr[n0 + 1], 32'h0000_0500);
  endtask : t_retry
  task t_fault(input logic [1:0] f, input logic [31:0] a);
    @(posedge ref_clk);
    fault <= f;
    programmed_io(1'b1, ibc_pkg::SIZE_WORD, 1'b1, a, 1'b0);
    wt(1);
    cmp({pio_error, err_write, err_size, err_addr}, {2'h3, ibc_pkg::SIZE_WORD, a});
    fault <= 2'h0;
  endtask : t_fault
  task t_virtual_dma_transfer(input logic loc);
    n0 = as_addr.size();
    @(posedge ref_clk);
    virtual_dma_transfer_local <= loc;
    programmed_io(1'b1, ibc_pkg::SIZE_WORD, 1'b1, 32'h0000_0300, 1'b1);
    if (loc)
    begin
      wt(2);
      cmp({as_addr.size(), virtual_dma_transfer_slave_sel}, {n0, 1'b1});
      done_pulse;
      wt(3);
    end
    else
    begin
      #1;
      cmp({virtual_dma_transfer_busy, virtual_dma_transfer_get, virtual_dma_transfer_put, virtual_dma_transfer_slave_sel}, 4'h8);
    end
    done_pulse;
    wt(4);
    wt(1);
    cmp(as_addr.size(), n0 + 1);
  endtask : t_virtual_dma_transfer
  task t_virtual_dma_transfer_wd;
    n0 = as_addr.size();
    @(posedge ref_clk);
    virtual_dma_transfer_local <= 1'b1;
    virtual_dma_transfer_write <= 1'b1;
    programmed_io(1'b1, ibc_pkg::SIZE_WORD, 1'b1, 32'h0000_0800, 1'b1);
    wt(2);
    wt(6);
    cmp({virtual_dma_transfer_err_ack, virtual_dma_transfer_put, virtual_dma_transfer_slave_sel}, 3'h7);
    done_pulse;
    wt(4);
    wt(1);
    cmp(as_addr.size(), n0 + 1);
  endtask : t_virtual_dma_transfer_wd
  task t_reset;
    n0 = as_addr.size();
    fault <= 2'h3;
    programmed_io(1'b0, ibc_pkg::SIZE_WORD, 1'b1, 32'h0000_0900, 1'b0);
    wt(5);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    fault <= 2'h0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    cmp({controller_pending, bus_req, bus_as, read_ready_request, pio_error}, 5'h00);
    programmed_io(1'b0, ibc_pkg::SIZE_WORD, 1'b1, 32'h0000_0a00, 1'b0);
    wt(0);
    cmp(cpu_rdata[63:32], EXP_RD);
  endtask : t_reset
  initial
  begin
    {rst_n, cpu_write, slot_burst_ok, virtual_dma_transfer_trans_done, virtual_dma_transfer_local, virtual_dma_transfer_done} = 6'h00;
    {clk_en, cycle_strobe_n, virtual_dma_transfer_write, virtual_dma_transfer_len} = 8'hd0;
    {cpu_size, fault, cpu_paddr} = 36'h0_0000_0000;
    cpu_wdata = 64'h1234_5678_9abc_def0;
    {err_total, comparisons, n0} = 96'h0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    cmp({controller_pending, bus_req, bus_as, virtual_dma_transfer_busy}, 4'h0);
    t_read;
    t_write_split;
    t_retry;
    t_fault(2'h1, 32'h0000_0600);
    t_fault(2'h3, 32'h0000_0700);
    t_virtual_dma_transfer(1'b1);
    t_virtual_dma_transfer(1'b0);
    t_virtual_dma_transfer_wd;
    t_reset;
    results;
  end
endmodule : ibc_cpu_port_tb
`default_nettype wire

//--- ibc_pkg.sv
// Purpose: shared constants and types for the processor-side port of the io bus controller
// Assumes: one clock, no software registers
// Notes: sizes follow the bus encoding used on the processor side
package ibc_pkg;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_DWORD = 2'h3;
  localparam int unsigned BURST_MAX_BYTES = 16;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned WDOG_TIME_NS = 2560;
  localparam int unsigned WDOG_CYCLES = WDOG_TIME_NS / CLK_PERIOD_NS;
  localparam logic [31:0] RESET_ADDR = 32'h0000_0000;
  localparam logic [63:0] RESET_DATA = 64'h0000_0000_0000_0000;
  localparam int unsigned WORD_STEP = 4;
  typedef enum logic [2:0]
  {
    CSM_IDLE = 3'b000,
    CSM_REQ = 3'b001,
    CSM_GRANT = 3'b011,
    CSM_HOLD = 3'b010,
    CSM_HOUSE = 3'b110,
    CSM_VIRTUAL_DMA_TRANSFER_GET = 3'b111,
    CSM_VIRTUAL_DMA_TRANSFER_PUT = 3'b101,
    CSM_VIRTUAL_DMA_TRANSFER_BYP = 3'b100
  } ibc_state_t;
endpackage : ibc_pkg

//--- ibc_wdog.sv
// Purpose: watchdog counter for slave cycles
// Assumes: run is high while a slave cycle is open
// Notes: expire is a one-cycle pulse when the limit is reached
`timescale 1ns/1ps
`default_nettype none
module ibc_wdog
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic run,
  output logic expire
);
  logic [9:0] cnt_q;
  wire limit_hit = (cnt_q == 10'(ibc_pkg::WDOG_CYCLES - 1));
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 10'h000;
      expire <= 1'b0;
    end
    else if (clk_en)
    begin
      cnt_q <= (run && !limit_hit) ? cnt_q + 10'h001 : 10'h000;
      expire <= run && limit_hit;
    end
  end
endmodule : ibc_wdog
`default_nettype wire
